// ==== rtl/osc_startup_regs.vh ====
`ifndef OSC_STARTUP_REGS_VH
`define OSC_STARTUP_REGS_VH
// Oscillator select field codes
`define OSC_SEL_LOW_GAIN 3'h0
`define OSC_SEL_MED_GAIN 3'h1
`define OSC_SEL_HIGH_GAIN 3'h2
`define OSC_SEL_EXT_CLOCK 3'h3
`define OSC_SEL_INTERNAL 3'h4
// System clock select codes
`define SYS_SEL_PRIMARY 2'h0
`define SYS_SEL_SECONDARY 2'h1
`define SYS_SEL_INTERNAL 2'h2
// Amplifier gain codes
`define GAIN_OFF 2'h0
`define GAIN_LOW 2'h1
`define GAIN_MED 2'h2
`define GAIN_HIGH 2'h3
// Start-up timer length in primary oscillator cycles
`define OST_CYCLES 11'h400
// Reset values
`define OST_COUNT_RESET 11'h000
`define FLAG_RESET 1'b0
`endif

// ==== rtl/primary_osc_two_speed_startup.v ====
// Contract
// - Software controls the primary oscillator only when the allow bit is set.
// - With software control, run bit one runs oscillator, zero stops it.
// - Primary oscillator stops while it is the selected system clock only in sleep.
// - Crystal mode picks low, medium or high amplifier gain.
// - Two-speed start-up runs code from internal oscillator during timer count.
// - Crystal primary clock holds execution for 1024 cycles unless two-speed.
// - Two-speed switches system clock to primary once timer expires.
// - Start-up applies after power-on reset, power-up delay, and wake-up.
// - Status bit set on configured oscillator, clear on internal oscillator.
`timescale 1ns/100ps
`default_nettype none
`include "osc_startup_regs.vh"
module primary_osc_two_speed_startup #(
   parameter [10:0] OST_LEN = `OST_CYCLES
) (
   input wire ref_clk_in,
   input wire rst_in,
   input wire [2:0] osc_select_field_in,
   input wire primary_sw_control_allow_in,
   input wire primary_osc_run_bit_in,
   input wire two_speed_startup_enable_in,
   input wire [1:0] sys_clk_select_in,
   input wire por_event_in,
   input wire powerup_delay_timer_enable_in,
   input wire powerup_delay_done_in,
   input wire wake_event_in,
   input wire sleep_in,
   input wire primary_osc_edge_in,
   output wire primary_osc_enable_out,
   output wire [1:0] amp_gain_out,
   output wire exec_enable_out,
   output wire sys_clk_internal_out,
   output wire startup_status_bit_out
);
   localparam ST_IDLE = 2'h0;
   localparam ST_COUNT = 2'h1;
   localparam ST_RUN = 2'h2;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [10:0] ost_count_reg;
   reg [10:0] ost_count_next;
   reg [1:0] amp_gain_reg;
   reg [1:0] amp_gain_next;
   reg exec_enable_reg;
   reg exec_enable_next;
   reg sys_clk_internal_reg;
   reg sys_clk_internal_next;
   reg startup_status_reg;
   reg startup_status_next;
   wire crystal_mode;
   wire primary_is_sys;
   wire internal_is_sys;
   wire sw_stop_request;
   wire por_start;
   wire delay_start;
   wire start_trigger;
   wire ost_last_count;
   wire ost_done;

   // Three crystal codes drive the amplifier; the rest leave it off
   function is_crystal(input [2:0] sel);
      case (sel)
         `OSC_SEL_LOW_GAIN: is_crystal = 1'b1;
         `OSC_SEL_MED_GAIN: is_crystal = 1'b1;
         `OSC_SEL_HIGH_GAIN: is_crystal = 1'b1;
         default: is_crystal = 1'b0;
      endcase
   endfunction

   function [1:0] gain_for_mode(input [2:0] sel);
      case (sel)
         `OSC_SEL_LOW_GAIN: gain_for_mode = `GAIN_LOW;
         `OSC_SEL_MED_GAIN: gain_for_mode = `GAIN_MED;
         `OSC_SEL_HIGH_GAIN: gain_for_mode = `GAIN_HIGH;
         default: gain_for_mode = `GAIN_OFF;
      endcase
   endfunction

   assign crystal_mode = is_crystal(osc_select_field_in);
   // An internal-only configuration never makes the primary the system clock
   assign primary_is_sys = (sys_clk_select_in == `SYS_SEL_PRIMARY) &&
      (osc_select_field_in != `OSC_SEL_INTERNAL);
   assign internal_is_sys = (sys_clk_select_in == `SYS_SEL_INTERNAL);
   assign sw_stop_request = primary_sw_control_allow_in && !primary_osc_run_bit_in;
   // Run bit ignored unless allowed; active system clock is stopped only by sleep
   assign primary_osc_enable_out = !sleep_in &&
      (primary_is_sys || !sw_stop_request);
   // Delay completion replaces the reset event when that timer is on
   assign por_start = por_event_in && !powerup_delay_timer_enable_in;
   assign delay_start = powerup_delay_done_in && powerup_delay_timer_enable_in;
   assign start_trigger = por_start || delay_start || wake_event_in;
   assign ost_last_count = (ost_count_reg == OST_LEN - 11'h001);
   assign ost_done = ost_last_count && primary_osc_edge_in;

   assign amp_gain_out = amp_gain_reg;
   assign exec_enable_out = exec_enable_reg;
   assign sys_clk_internal_out = sys_clk_internal_reg;
   assign startup_status_bit_out = startup_status_reg;

   always @* begin
      amp_gain_next = gain_for_mode(osc_select_field_in);
   end

   always @* begin
      state_next = state_reg;
      ost_count_next = ost_count_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_trigger && primary_is_sys && crystal_mode) begin
               state_next = ST_COUNT;
               ost_count_next = `OST_COUNT_RESET;
            end else if (start_trigger) begin
               state_next = ST_RUN;
            end
         end
         ST_COUNT: begin
            // Sleep drops the oscillator, so the count starts over on wake
            if (sleep_in) begin
               state_next = ST_IDLE;
            end else if (ost_done) begin
               state_next = ST_RUN;
            end else if (primary_osc_edge_in) begin
               ost_count_next = ost_count_reg + 11'h001;
            end
         end
         ST_RUN: begin
            if (sleep_in) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Outputs follow the next state, so status and clock swap together
   always @* begin
      case (state_next)
         ST_COUNT: begin
            exec_enable_next = two_speed_startup_enable_in;
         end
         ST_RUN: begin
            exec_enable_next = 1'b1;
         end
         default: begin
            exec_enable_next = `FLAG_RESET;
         end
      endcase
   end

   always @* begin
      case (state_next)
         ST_COUNT: begin
            sys_clk_internal_next = two_speed_startup_enable_in;
         end
         ST_RUN: begin
            sys_clk_internal_next = internal_is_sys;
         end
         default: begin
            sys_clk_internal_next = `FLAG_RESET;
         end
      endcase
   end

   always @* begin
      case (state_next)
         ST_COUNT: begin
            startup_status_next = 1'b0;
         end
         ST_RUN: begin
            startup_status_next = !internal_is_sys;
         end
         default: begin
            startup_status_next = `FLAG_RESET;
         end
      endcase
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         ost_count_reg <= `OST_COUNT_RESET;
      end else begin
         ost_count_reg <= ost_count_next;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         amp_gain_reg <= `GAIN_OFF;
      end else begin
         amp_gain_reg <= amp_gain_next;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         exec_enable_reg <= `FLAG_RESET;
      end else begin
         exec_enable_reg <= exec_enable_next;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         sys_clk_internal_reg <= `FLAG_RESET;
      end else begin
         sys_clk_internal_reg <= sys_clk_internal_next;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         startup_status_reg <= `FLAG_RESET;
      end else begin
         startup_status_reg <= startup_status_next;
      end
   end
endmodule // primary_osc_two_speed_startup
`default_nettype wire

// ==== dv/crystal_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module crystal_model (input wire logic clk_in, en_in, output logic edge_out = 1'h0);
   // Rising-edge update keeps the pulse clear of falling-edge stimulus; silent while disabled
   always @(posedge clk_in) edge_out <= en_in & ~edge_out;
endmodule // crystal_model
`default_nettype wire

// ==== dv/osc_startup_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module osc_startup_asserts (input wire logic ref_clk_in, rst_in, sleep_in, exec_enable_out,
   primary_sw_control_allow_in, primary_osc_run_bit_in, primary_osc_enable_out,
   sys_clk_internal_out, startup_status_bit_out, input wire logic [1:0] sys_clk_select_in,
   amp_gain_out, input wire logic [2:0] osc_select_field_in);
   wire logic al = primary_sw_control_allow_in, rn = primary_osc_run_bit_in;
   wire logic en = primary_osc_enable_out, si = sys_clk_internal_out, ex = exec_enable_out;
   wire logic st = startup_status_bit_out;
   wire logic pr = sys_clk_select_in == 2'h0 && osc_select_field_in != 3'h4;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   property p_f; !al && !sleep_in |-> en; endproperty
   a_f: assert property (p_f) else $error("free");
   property p_r; al && rn && !sleep_in |-> en; endproperty
   a_r: assert property (p_r) else $error("run");
   property p_s; al && !rn && !pr && !sleep_in |-> !en; endproperty
   a_s: assert property (p_s) else $error("stop");
   property p_k; pr && !sleep_in |-> en; endproperty
   a_k: assert property (p_k) else $error("keep");
   property p_t; $rose(si) |-> ex && !st; endproperty
   a_t: assert property (p_t) else $error("fast");
   property p_w; $fell(si) && ex |-> st; endproperty
   a_w: assert property (p_w) else $error("switch");
   property p_i; si |-> !st; endproperty
   a_i: assert property (p_i) else $error("internal");
   property p_u; $rose(st) |-> ex && !si; endproperty
   a_u: assert property (p_u) else $error("status");
   property p_e; $rose(ex) |-> st || si; endproperty
   a_e: assert property (p_e) else $error("exec");
   property p_g; osc_select_field_in == 3'h0 |=> amp_gain_out == 2'h1; endproperty
   a_g: assert property (p_g) else $error("lowgain");
   property p_h; osc_select_field_in == 3'h2 |=> amp_gain_out == 2'h3; endproperty
   a_h: assert property (p_h) else $error("highgain");
endmodule // osc_startup_asserts
bind primary_osc_two_speed_startup osc_startup_asserts i_osc_startup_asserts (.*);
`default_nettype wire

// ==== dv/primary_osc_two_speed_startup_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module primary_osc_two_speed_startup_test;
   logic ref_clk_in = 1'h0, rst_in = 1'h1, al = 1'h0, rn = 1'h1, ts = 1'h0, pd = 1'h0, sl = 1'h0;
   logic en, xe, ex, si, st;
   logic [1:0] sys = 2'h0, gn;
   logic [2:0] sel = 3'h2, ev = 3'h0;
   int fails = 0, comparisons = 0;
   always #5 ref_clk_in = ~ref_clk_in;
   crystal_model i_crystal_model (.clk_in(ref_clk_in), .en_in(en), .edge_out(xe));
   primary_osc_two_speed_startup #(.OST_LEN(11'h008)) i_primary_osc_two_speed_startup (
      .ref_clk_in, .rst_in, .osc_select_field_in(sel), .primary_sw_control_allow_in(al),
      .primary_osc_run_bit_in(rn), .two_speed_startup_enable_in(ts), .sleep_in(sl),
      .sys_clk_select_in(sys), .por_event_in(ev[0]), .powerup_delay_done_in(ev[1]),
      .wake_event_in(ev[2]), .powerup_delay_timer_enable_in(pd), .primary_osc_edge_in(xe),
      .primary_osc_enable_out(en), .amp_gain_out(gn), .exec_enable_out(ex),
      .sys_clk_internal_out(si), .startup_status_bit_out(st));
   task cy(input int n); repeat (n) @(negedge ref_clk_in); endtask
   task chk(input logic [2:0] e, g, input string n); comparisons++;
      if (g !== e) begin fails++; $display("[ERR] %s expected %h seen %h", n, e, g); end endtask
   task fire(input logic [2:0] k); // Sleep first so the trigger meets an idle block
      sl = 1'h1; cy(1); sl = 1'h0; ev = k; cy(1); ev = 3'h0; cy(1); endtask
   task print_verdict; if (fails == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish; endtask
   task t_plain; fire(3'h1); cy(7); chk(3'h0, {ex, si, st}, "held");
      cy(20); chk(3'h5, {ex, si, st}, "run"); chk(3'h3, {1'h0, gn}, "gain"); endtask
   task t_fast; ts = 1'h1; fire(3'h4); chk(3'h6, {ex, si, st}, "fast");
      cy(30); chk(3'h5, {ex, si, st}, "switch"); ts = 1'h0; endtask
   task t_nap; ts = 1'h1; fire(3'h4); cy(6); sl = 1'h1; cy(2); // Sleep cuts the count
      chk(3'h0, {ex, si, st}, "nap"); sl = 1'h0; ev = 3'h4; cy(1); ev = 3'h0; cy(12);
      chk(3'h6, {ex, si, st}, "restart"); cy(20); chk(3'h5, {ex, si, st}, "woken");
      ts = 1'h0; endtask
   task t_ext; sel = 3'h3; fire(3'h1); chk(3'h5, {ex, si, st}, "ext");
      chk(3'h0, {1'h0, gn}, "nogain"); sel = 3'h2; cy(2); endtask
   task t_powerup_delay_timer; pd = 1'h1; fire(3'h1); cy(20); chk(3'h0, {ex, si, st}, "por");
      fire(3'h2); cy(30); chk(3'h5, {ex, si, st}, "delay"); pd = 1'h0; endtask
   task t_gain; for (int i = 0; i < 3; i++) begin sel = 3'(i); cy(2); // Every crystal mode
      chk(3'(i + 1), {1'h0, gn}, "gain"); end endtask
   task t_sd; al = 1'h1; rn = 1'h0; sys = 2'h1; cy(1); chk(3'h0, {2'h0, en}, "off");
      sys = 2'h0; cy(1); chk(3'h1, {2'h0, en}, "kept"); rn = 1'h1; sys = 2'h2;
      cy(1); chk(3'h1, {2'h0, en}, "on");
      chk(3'h6, {ex, si, st}, "intclk"); al = 1'h0; rn = 1'h0; cy(1);
      chk(3'h1, {2'h0, en}, "free"); endtask
   initial begin
      cy(12);
      rst_in = 1'h0;
      t_plain;
      t_fast;
      t_nap;
      t_powerup_delay_timer;
      t_gain;
      t_ext;
      t_sd;
      print_verdict;
   end
   initial begin #20000; fails++; print_verdict; end // Tests take about 200 cycles
endmodule // primary_osc_two_speed_startup_test
`default_nettype wire
